/* core/dpfs_defs.vh */
// constants and register map of the dual multipurpose pin function selector
// Behaviour
// - first pin code holds 0..4, resets to 0, changes only in half duplex.
// - second pin code holds 0..4, resets to 0, changes only in half duplex.
// - first pin code 0 leaves pin unused; full duplex stays selectable.
// - second pin code 0 leaves pin unused; full duplex stays selectable.
// - first pin code 1 converts pin cyclically to 16 bits, speed output off.
// - second pin code 1 converts pin cyclically to 16 bits, direction output off.
// - first pin code 2 reads back own speed output and converts it cyclically.
// - second pin code 2 reads back own direction output through the input.
// - first pin code 3 drives speed output unless output mode selector is 2.
// - second pin code 3 drives direction output unless output mode selector is 2.
// - first pin code 4 samples the pin as identifier bit 0.
// - second pin code 4 samples the pin as identifier bit 1.
// - third pin code 4 supplies identifier bit 2, completing three bits.
`ifndef DPFS_DEFS_VH
`define DPFS_DEFS_VH

// register byte offsets
`define DPFS_PINS_OFF 8'h00
`define DPFS_LINK_OFF 8'h04
`define DPFS_STAT_OFF 8'h08
`define DPFS_VAL1_OFF 8'h0C
`define DPFS_VAL2_OFF 8'h10

// pin function register fields (one byte lane each)
`define DPFS_PIN1_LSB 0
`define DPFS_PIN2_LSB 8
`define DPFS_PIN3_LSB 16
`define DPFS_CODE_W 5

// link register fields
`define DPFS_DUPLEX_BIT 0
`define DPFS_AOMODE_LSB 4
`define DPFS_AOMODE_W 3
`define DPFS_XID_BIT 8

// status register fields
`define DPFS_ERR_BIT 0
`define DPFS_FDOK_BIT 1
`define DPFS_ID_LSB 4

// function codes and limits
`define DPFS_CODE_UNUSED 5'h00
`define DPFS_CODE_ANALOG_IN 5'h01
`define DPFS_CODE_SELFTEST 5'h02
`define DPFS_CODE_ANALOG_OUT 5'h03
`define DPFS_CODE_IDENT 5'h04
`define DPFS_CODE_MAX 5'h04
`define DPFS_CODE3_MAX 5'h14
`define DPFS_AOMODE_BLOCK 3'h2

// reset values
`define DPFS_CODE_RST 5'h00
`define DPFS_AOMODE_RST 3'h0

// bus responses
`define DPFS_RESP_OKAY 2'h0
`define DPFS_RESP_SLVERR 2'h2

// conversion cadence
`define DPFS_CLK_PERIOD_NS 40
`define DPFS_CONV_PERIOD_NS 1000
`define DPFS_CONV_CYCLES (`DPFS_CONV_PERIOD_NS / `DPFS_CLK_PERIOD_NS)

`endif

/* core/dpfs_pin_select.v */
// dual multipurpose pin function selector with axi4-lite register access
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`include "dpfs_defs.vh"

module dpfs_pin_select #(
  parameter CONV_CYCLES = `DPFS_CONV_CYCLES,
  parameter VAL_W = 16
) (
  input wire aclk, // 25 mhz system clock
  input wire aresetn, // synchronous reset, active low
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte enables
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire [2:0] pin_level, // digital level of pins 1, 2, 3
  input wire [2*VAL_W-1:0] adc_value, // converter results, pin 2 high half
  input wire [1:0] adc_done, // converter result strobes
  output reg [1:0] adc_start, // conversion request pulses
  output reg [1:0] adc_readback, // converter input taken from own output
  output reg wind_speed_output_en, // speed analog output on
  output reg wind_direction_output_en, // direction analog output on
  output reg link_full_duplex, // serial link runs full duplex
  output reg [2:0] strapped_device_identifier, // externally strapped id
  output reg [VAL_W-1:0] pin1_value, // pin 1 converted value for telegram
  output reg [VAL_W-1:0] pin2_value // pin 2 converted value for telegram
);

  // accepted range check for a pin code
  function code_legal;
    input [`DPFS_CODE_W-1:0] code;
    input [`DPFS_CODE_W-1:0] limit;
    begin
      code_legal = (code <= limit);
    end
  endfunction

  // pin code uses the converter (plain input or self-test readback)
  function code_converts;
    input [`DPFS_CODE_W-1:0] code;
    begin
      code_converts = (code == `DPFS_CODE_ANALOG_IN) || (code == `DPFS_CODE_SELFTEST);
    end
  endfunction

  // configuration state
  reg [`DPFS_CODE_W-1:0] first_pin_function_code_q;
  reg [`DPFS_CODE_W-1:0] second_pin_function_code_q;
  reg [`DPFS_CODE_W-1:0] third_pin_function_code_q;
  reg link_duplex_selector_q;
  reg [`DPFS_AOMODE_W-1:0] analog_output_mode_selector_q;
  reg external_identifier_select_q;
  reg err_q;

  // write channel holding registers
  reg aw_hold_q;
  reg [7:0] aw_addr_q;
  reg w_hold_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  // pin synchroniser
  reg [2:0] pin_meta_q;
  reg [2:0] pin_sync_q;

  // per-channel converter state
  reg [15:0] conv_cnt_q [0:1];
  reg [VAL_W-1:0] conv_val_q [0:1];

  wire do_write;
  wire half_duplex;
  wire [`DPFS_CODE_W-1:0] new_code1;
  wire [`DPFS_CODE_W-1:0] new_code2;
  wire [`DPFS_CODE_W-1:0] new_code3;
  wire [`DPFS_CODE_W-1:0] code_ch [0:1];
  wire code1_bad;
  wire code2_bad;
  wire code3_bad;
  wire fd_ok;
  wire fd_req_bad;
  wire pins_hit;
  wire link_hit;
  wire stat_hit;
  wire write_mapped;
  wire write_err;
  wire err_clear;
  wire ao_allowed;

  // only one write may be in flight; both halves are parked until answered
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;

  // write address decode
  assign pins_hit = (aw_addr_q == `DPFS_PINS_OFF);
  assign link_hit = (aw_addr_q == `DPFS_LINK_OFF);
  assign stat_hit = (aw_addr_q == `DPFS_STAT_OFF);
  assign write_mapped = pins_hit || link_hit || stat_hit;

  assign half_duplex = !link_duplex_selector_q;
  assign new_code1 = w_data_q[`DPFS_PIN1_LSB +: `DPFS_CODE_W];
  assign new_code2 = w_data_q[`DPFS_PIN2_LSB +: `DPFS_CODE_W];
  assign new_code3 = w_data_q[`DPFS_PIN3_LSB +: `DPFS_CODE_W];

  // a lane write is bad if out of range, or a real change while full duplex
  assign code1_bad = pins_hit && w_strb_q[0] && (!code_legal(new_code1, `DPFS_CODE_MAX) ||
    (!half_duplex && new_code1 != first_pin_function_code_q));
  assign code2_bad = pins_hit && w_strb_q[1] && (!code_legal(new_code2, `DPFS_CODE_MAX) ||
    (!half_duplex && new_code2 != second_pin_function_code_q));
  // third pin is independent of duplex, only its range is checked
  assign code3_bad = pins_hit && w_strb_q[2] && !code_legal(new_code3, `DPFS_CODE3_MAX);

  // full duplex may be chosen only while both pins are unused
  assign fd_ok = (first_pin_function_code_q == `DPFS_CODE_UNUSED) &&
    (second_pin_function_code_q == `DPFS_CODE_UNUSED);
  assign fd_req_bad = link_hit && w_strb_q[0] && w_data_q[`DPFS_DUPLEX_BIT] && !fd_ok;

  assign write_err = code1_bad || code2_bad || code3_bad || fd_req_bad;
  assign err_clear = do_write && stat_hit && w_strb_q[0] && w_data_q[`DPFS_ERR_BIT];

  // analog outputs in azimuth are blocked when the mode selector is 2
  assign ao_allowed = (analog_output_mode_selector_q != `DPFS_AOMODE_BLOCK);

  assign code_ch[0] = first_pin_function_code_q;
  assign code_ch[1] = second_pin_function_code_q;

  // write address and data capture, either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end else if (do_write) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // write response one cycle after both halves are held
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DPFS_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= write_mapped ? `DPFS_RESP_OKAY : `DPFS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // pin function codes; each lane is judged on its own
  always @(posedge aclk) begin
    if (!aresetn) begin
      first_pin_function_code_q <= `DPFS_CODE_RST;
      second_pin_function_code_q <= `DPFS_CODE_RST;
      third_pin_function_code_q <= `DPFS_CODE_RST;
    end else if (do_write && pins_hit) begin
      if (w_strb_q[0] && !code1_bad) begin
        first_pin_function_code_q <= new_code1;
      end
      if (w_strb_q[1] && !code2_bad) begin
        second_pin_function_code_q <= new_code2;
      end
      if (w_strb_q[2] && !code3_bad) begin
        third_pin_function_code_q <= new_code3;
      end
    end
  end

  // link settings; a refused duplex request leaves the link as it was
  always @(posedge aclk) begin
    if (!aresetn) begin
      link_duplex_selector_q <= 1'b0;
      analog_output_mode_selector_q <= `DPFS_AOMODE_RST;
      external_identifier_select_q <= 1'b0;
    end else if (do_write && link_hit) begin
      if (w_strb_q[0] && !fd_req_bad) begin
        link_duplex_selector_q <= w_data_q[`DPFS_DUPLEX_BIT];
      end
      if (w_strb_q[0]) begin
        analog_output_mode_selector_q <= w_data_q[`DPFS_AOMODE_LSB +: `DPFS_AOMODE_W];
      end
      if (w_strb_q[1]) begin
        external_identifier_select_q <= w_data_q[`DPFS_XID_BIT];
      end
    end
  end

  // sticky refusal flag; a new refusal wins over a clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      err_q <= 1'b0;
    end else if (do_write && write_err) begin
      err_q <= 1'b1;
    end else if (err_clear) begin
      err_q <= 1'b0;
    end
  end

  // read channel, answered one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DPFS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `DPFS_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      case ({s_axi_araddr[7:2], 2'b00})
        `DPFS_PINS_OFF: begin
          s_axi_rdata[`DPFS_PIN1_LSB +: `DPFS_CODE_W] <= first_pin_function_code_q;
          s_axi_rdata[`DPFS_PIN2_LSB +: `DPFS_CODE_W] <= second_pin_function_code_q;
          s_axi_rdata[`DPFS_PIN3_LSB +: `DPFS_CODE_W] <= third_pin_function_code_q;
        end
        `DPFS_LINK_OFF: begin
          s_axi_rdata[`DPFS_DUPLEX_BIT] <= link_duplex_selector_q;
          s_axi_rdata[`DPFS_AOMODE_LSB +: `DPFS_AOMODE_W] <= analog_output_mode_selector_q;
          s_axi_rdata[`DPFS_XID_BIT] <= external_identifier_select_q;
        end
        `DPFS_STAT_OFF: begin
          s_axi_rdata[`DPFS_ERR_BIT] <= err_q;
          s_axi_rdata[`DPFS_FDOK_BIT] <= fd_ok;
          s_axi_rdata[`DPFS_ID_LSB +: 3] <= strapped_device_identifier;
        end
        `DPFS_VAL1_OFF: begin
          s_axi_rdata[VAL_W-1:0] <= conv_val_q[0];
        end
        `DPFS_VAL2_OFF: begin
          s_axi_rdata[VAL_W-1:0] <= conv_val_q[1];
        end
        default: begin
          s_axi_rresp <= `DPFS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // pins come from outside, two flops before anything looks at them
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end else begin
      pin_meta_q <= pin_level;
      pin_sync_q <= pin_meta_q;
    end
  end

  // cyclic conversion per pin; the converter source follows the code
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_conv
      always @(posedge aclk) begin
        if (!aresetn) begin
          conv_cnt_q[gi] <= 16'h0000;
          conv_val_q[gi] <= {VAL_W{1'b0}};
          adc_start[gi] <= 1'b0;
          adc_readback[gi] <= 1'b0;
        end else begin
          adc_start[gi] <= 1'b0;
          // self-test routes the own output back into the converter
          adc_readback[gi] <= (code_ch[gi] == `DPFS_CODE_SELFTEST);
          if (!code_converts(code_ch[gi])) begin
            // idle channels restart the cadence so a new mode starts at once
            conv_cnt_q[gi] <= 16'h0000;
          // switching between plain input and readback restarts the cadence at once,
          // so the first readback result never comes from a conversion of the pin
          end else if ((conv_cnt_q[gi] == 16'h0000) ||
              ((code_ch[gi] == `DPFS_CODE_SELFTEST) != adc_readback[gi])) begin
            conv_cnt_q[gi] <= CONV_CYCLES[15:0] - 16'h0001;
            adc_start[gi] <= 1'b1;
          end else begin
            conv_cnt_q[gi] <= conv_cnt_q[gi] - 16'h0001;
          end
          // stale results after a change to a non-converting code are dropped
          if (adc_done[gi] && code_converts(code_ch[gi])) begin
            conv_val_q[gi] <= adc_value[gi*VAL_W +: VAL_W];
          end
        end
      end
    end
  endgenerate

  // analog output enables, identifier and telegram values
  always @(posedge aclk) begin
    if (!aresetn) begin
      wind_speed_output_en <= 1'b0;
      wind_direction_output_en <= 1'b0;
      link_full_duplex <= 1'b0;
      strapped_device_identifier <= 3'h0;
      pin1_value <= {VAL_W{1'b0}};
      pin2_value <= {VAL_W{1'b0}};
    end else begin
      // analog input code turns the output off; self-test needs it running
      wind_speed_output_en <= (first_pin_function_code_q == `DPFS_CODE_SELFTEST) ||
        ((first_pin_function_code_q == `DPFS_CODE_ANALOG_OUT) && ao_allowed);
      wind_direction_output_en <= (second_pin_function_code_q == `DPFS_CODE_SELFTEST) ||
        ((second_pin_function_code_q == `DPFS_CODE_ANALOG_OUT) && ao_allowed);
      link_full_duplex <= link_duplex_selector_q;
      // identifier bits only count when external identifier mode is chosen
      strapped_device_identifier[0] <= external_identifier_select_q &&
        (first_pin_function_code_q == `DPFS_CODE_IDENT) && pin_sync_q[0];
      strapped_device_identifier[1] <= external_identifier_select_q &&
        (second_pin_function_code_q == `DPFS_CODE_IDENT) && pin_sync_q[1];
      strapped_device_identifier[2] <= external_identifier_select_q &&
        (third_pin_function_code_q == `DPFS_CODE_IDENT) && pin_sync_q[2];
      // converted values, plain input or readback, go to the telegram builder
      pin1_value <= conv_val_q[0];
      pin2_value <= conv_val_q[1];
    end
  end

endmodule // dpfs_pin_select

/* testbench/dpfs_adc_model.sv */
// behavioural converter front end answering the selector's conversion requests
module dpfs_adc_model #(
  parameter logic [15:0] RB_VAL = 16'h5A3C // level read back from own output
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [1:0] adc_start, // conversion requests
  input wire logic [1:0] adc_readback, // read own output instead of pin
  input wire logic [15:0] ain1, // pin 1 level
  input wire logic [15:0] ain2, // pin 2 level
  input wire logic [3:0] lat, // conversion time in cycles, 1 or more
  output logic [1:0] adc_done, // result strobes
  output logic [31:0] adc_value // results, pin 2 high half
);
  logic [3:0] cnt_q [2];
  logic [15:0] v_q [2];
  // one countdown per channel; a new request restarts it
  always @(posedge aclk) begin
    for (int i = 0; i < 2; i++) begin
      adc_done[i] <= 1'b0;
      if (!aresetn) begin
        cnt_q[i] <= 4'h0;
        v_q[i] <= 16'h0000;
      end else if (adc_start[i]) begin
        cnt_q[i] <= lat;
      end else if (cnt_q[i] == 4'h1) begin
        cnt_q[i] <= 4'h0;
        adc_done[i] <= 1'b1;
        v_q[i] <= adc_readback[i] ? RB_VAL : (i == 0 ? ain1 : ain2);
      end else if (cnt_q[i] != 4'h0) begin
        cnt_q[i] <= cnt_q[i] - 4'h1;
      end
    end
  end
  // outside the strobe the bus shows garbage, not the last result
  assign adc_value = {adc_done[1] ? v_q[1] : ~v_q[1], adc_done[0] ? v_q[0] : ~v_q[0]};
endmodule // dpfs_adc_model

/* testbench/dpfs_chk_asserts.sv */
// concurrent checks on the pin selector ports
module dpfs_chk (
  input wire aclk, // clock
  input wire aresetn, // sync reset, active low
  input wire s_axi_awready, // write address ready
  input wire s_axi_wready, // write data ready
  input wire [1:0] s_axi_bresp, // write response
  input wire s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire s_axi_arvalid, // read address valid
  input wire s_axi_arready, // read address ready
  input wire [31:0] s_axi_rdata, // read data
  input wire s_axi_rvalid, // read valid
  input wire s_axi_rready, // read ready
  input wire [1:0] adc_start, // conversion pulses
  input wire [1:0] adc_readback, // readback select
  input wire wind_speed_output_en, // speed output on
  input wire wind_direction_output_en, // direction output on
  input wire link_full_duplex, // full duplex
  input wire [2:0] strapped_device_identifier // strapped id
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rb_up(b);
    $rose(b);
  endsequence
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer missing");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  spd_readback_a: assert property (adc_readback[0] |-> wind_speed_output_en)
    else $error("speed output off during readback");
  dir_readback_a: assert property (adc_readback[1] |-> wind_direction_output_en)
    else $error("direction output off during readback");
  fdx_quiet_a: assert property (link_full_duplex |-> adc_readback == 2'h0 && adc_start == 2'h0
    && !wind_speed_output_en && !wind_direction_output_en && strapped_device_identifier[1:0] == 2'h0)
    else $error("pin function active in full duplex");
  spd_rb_start_a: assert property (rb_up(adc_readback[0]) |-> ##[0:2] adc_start[0])
    else $error("no conversion after pin 1 readback on");
  dir_rb_start_a: assert property (rb_up(adc_readback[1]) |-> ##[0:2] adc_start[1])
    else $error("no conversion after pin 2 readback on");
  start_pulse_a: assert property (adc_start[0] |=> !adc_start[0])
    else $error("conversion request longer than one cycle");
endmodule // dpfs_chk

bind dpfs_pin_select dpfs_chk chk_u (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .adc_start, .adc_readback, .wind_speed_output_en,
  .wind_direction_output_en, .link_full_duplex, .strapped_device_identifier);

/* testbench/dpfs_tb.sv */
// self-checking bench for the pin selector with a converter model
`include "dpfs_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 4;
  localparam logic [15:0] RBV = 16'h5A3C;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rv;
  logic [3:0] s_axi_wstrb = 0, lat = 1;
  logic [2:0] pin_level = 0;
  logic [15:0] ain1 = 0, ain2 = 0;
  logic [1:0] br, rr;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, adc_done, adc_start, adc_readback;
  wire [31:0] s_axi_rdata, adc_value;
  wire wind_speed_output_en, wind_direction_output_en, link_full_duplex;
  wire [2:0] strapped_device_identifier;
  wire [15:0] pin1_value, pin2_value;
  int n_fail = 0, num_checks = 0;
  always #20 aclk = ~aclk;
  dpfs_pin_select #(.CONV_CYCLES(CONV), .VAL_W(16)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_level, .adc_value,
    .adc_done, .adc_start, .adc_readback, .wind_speed_output_en, .wind_direction_output_en,
    .link_full_duplex, .strapped_device_identifier, .pin1_value, .pin2_value);
  dpfs_adc_model #(.RB_VAL(RBV)) adc_u (.aclk, .aresetn, .adc_start, .adc_readback, .ain1,
    .ain2, .lat, .adc_done, .adc_value);
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic hang;
    n_fail++;
    final_report();
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  // settled sampling point just after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    br = s_axi_bresp;
    s_axi_bready <= 0;
    if (i == 40) hang();
    tick(1);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
    if (i == 40) hang();
    chk(e, rv);
    tick(1);
  endtask
  task automatic t_reset;
    rdchk(`DPFS_PINS_OFF, 32'h0);
    rdchk(`DPFS_STAT_OFF, 32'h2);
    chk({link_full_duplex, wind_speed_output_en, wind_direction_output_en, adc_readback}, 0);
    rdchk(8'h20, 32'h0);
    chk(`DPFS_RESP_SLVERR, rr);
    wr(8'h20, 32'h1, 4'hF);
    chk(`DPFS_RESP_SLVERR, br);
    $display("reset test done");
  endtask
  task automatic t_duplex;
    wr(`DPFS_LINK_OFF, 32'h1, 4'h1);
    chk(1, link_full_duplex);
    wr(`DPFS_PINS_OFF, 32'h0101, 4'h3);
    chk(`DPFS_RESP_OKAY, br);
    rdchk(`DPFS_PINS_OFF, 32'h0);
    rdchk(`DPFS_STAT_OFF, 32'h3);
    wr(`DPFS_STAT_OFF, 32'h1, 4'h1);
    rdchk(`DPFS_STAT_OFF, 32'h2);
    wr(`DPFS_LINK_OFF, 32'h0, 4'h1);
    chk(0, link_full_duplex);
    // codes just past the legal top are refused, the top itself taken
    wr(`DPFS_PINS_OFF, 32'h0505, 4'h3);
    rdchk(`DPFS_PINS_OFF, 32'h0);
    wr(`DPFS_PINS_OFF, 32'h0404, 4'h3);
    rdchk(`DPFS_PINS_OFF, 32'h0404);
    wr(`DPFS_STAT_OFF, 32'h1, 4'h1);
    $display("duplex test done");
  endtask
  // every code on both pins, output mode selector 0 and the forbidden 2
  task automatic t_codes;
    logic en;
    for (int c = 0; c < 5; c++) begin
      for (int m = 0; m < 3; m += 2) begin
        wr(`DPFS_LINK_OFF, m << 4, 4'h1);
        wr(`DPFS_PINS_OFF, {c[7:0], c[7:0]}, 4'h3);
        tick(2);
        en = (c == 2) || (c == 3 && m != 2);
        chk({en, en, c == 2, c == 2}, {wind_speed_output_en, wind_direction_output_en, adc_readback});
        wr(`DPFS_LINK_OFF, (m << 4) | 1, 4'h1);
        chk(c == 0, link_full_duplex);
      end
    end
    wr(`DPFS_LINK_OFF, 32'h0, 4'h1);
    wr(`DPFS_STAT_OFF, 32'h1, 4'h1);
    $display("codes test done");
  endtask
  task automatic t_conv;
    int n;
    ain1 <= 16'h1234;
    wr(`DPFS_PINS_OFF, 32'h0201, 4'h3);
    for (n = 0; n < 40 && adc_start[0] !== 1'b1; n++) tick(1);
    for (n = 1; n < 40; n++) begin
      tick(1);
      if (adc_start[0] === 1'b1) break;
    end
    chk(CONV, n);
    tick(3 * CONV);
    rdchk(`DPFS_VAL1_OFF, 32'h1234);
    rdchk(`DPFS_VAL2_OFF, RBV);
    chk(16'h1234, pin1_value);
    // slow converter and full-scale value
    lat <= 3;
    ain1 <= 16'hFFFF;
    ain2 <= 16'h00C3;
    tick(4 * CONV);
    rdchk(`DPFS_VAL1_OFF, 32'hFFFF);
    wr(`DPFS_PINS_OFF, 32'h0102, 4'h3);
    tick(4 * CONV);
    rdchk(`DPFS_VAL1_OFF, RBV);
    rdchk(`DPFS_VAL2_OFF, 32'h00C3);
    chk(16'h00C3, pin2_value);
    wr(`DPFS_PINS_OFF, 32'h0, 4'h3);
    ain2 <= 16'h0001;
    tick(4 * CONV);
    rdchk(`DPFS_VAL2_OFF, 32'h00C3);
    $display("conversion test done");
  endtask
  task automatic t_ident;
    wr(`DPFS_LINK_OFF, 32'h100, 4'h2);
    rdchk(`DPFS_LINK_OFF, 32'h100);
    pin_level <= 3'b101;
    wr(`DPFS_PINS_OFF, 32'h040404, 4'h7);
    tick(4);
    chk(3'b101, strapped_device_identifier);
    rdchk(`DPFS_STAT_OFF, 32'h50);
    pin_level <= 3'b010;
    tick(4);
    chk(3'b010, strapped_device_identifier);
    wr(`DPFS_LINK_OFF, 32'h0, 4'h2);
    tick(4);
    chk(3'b000, strapped_device_identifier);
    $display("identifier test done");
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    tick(1);
    t_reset();
    t_duplex();
    t_codes();
    t_conv();
    t_ident();
    final_report();
  end
endmodule // testbench
